// ---- logic/bst_pkg.sv ----
// Purpose: shared constants and types of the boundary-scan test port
// Assumes: 4-bit instruction register, standard sixteen-state controller
// Notes:   instruction codes are local choices; all-ones is bypass
package bst_pkg;

   // ----------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------
   localparam int          IR_W        = 4;
   localparam logic [3:0]  IR_EXTEST   = 4'h0;
   localparam logic [3:0]  IR_SAMPLE   = 4'h1;
   localparam logic [3:0]  IR_IDCODE   = 4'h2;
   localparam logic [3:0]  IR_HIGHZ    = 4'h3;
   localparam logic [3:0]  IR_BYPASS   = 4'hF;
   localparam logic [3:0]  IR_CAPTURE  = 4'h1;

   // ----------------------------------------------------------------
   // data registers and chain layout
   // ----------------------------------------------------------------
   localparam int          ID_W        = 32;
   localparam int          CELL_STAGES = 3;
   localparam int          CAP_PIN     = 0;
   localparam int          CAP_OUT     = 1;
   localparam int          CAP_OE      = 2;
   localparam int          UPD_OUT     = 0;
   localparam int          UPD_OE      = 1;
   localparam int          N_IO_DEF    = 32;
   localparam int          N_IN_DEF    = 4;
   localparam int          N_MC_DEF    = 32;
   localparam int          TMS_RESET_EDGES = 5;

   // ----------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RESET    = 4'hF,
      ST_IDLE     = 4'hC,
      ST_SEL_DR   = 4'h7,
      ST_CAP_DR   = 4'h6,
      ST_SHIFT_DR = 4'h2,
      ST_EX1_DR   = 4'h1,
      ST_PAUSE_DR = 4'h3,
      ST_EX2_DR   = 4'h0,
      ST_UPD_DR   = 4'h5,
      ST_SEL_IR   = 4'h4,
      ST_CAP_IR   = 4'hE,
      ST_SHIFT_IR = 4'hA,
      ST_EX1_IR   = 4'h9,
      ST_PAUSE_IR = 4'hB,
      ST_EX2_IR   = 4'h8,
      ST_UPD_IR   = 4'hD
   } bst_tap_state_t;

endpackage : bst_pkg

// ---- logic/bst_scan_cell.sv ----
// Purpose: one scan cell: three capture/shift stages, up to two update stages
// Assumes: controls are one-cycle strobes from the test controller
// Notes:   HAS_UPD=0 gives the observe-only variant used for inputs and macrocells
`timescale 1ns/1ns
module bst_scan_cell #(
   parameter bit HAS_UPD = 1'b1
) (
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   input  wire logic       i_capture,
   input  wire logic       i_shift,
   input  wire logic       i_update,
   input  wire logic       i_si,
   input  wire logic [2:0] i_cap_data,
   output logic            o_so,
   output logic [1:0]      o_upd
);

   logic [2:0] cap_reg;
   logic [1:0] upd_reg;

   // ----------------------------------------------------------------
   // capture and shift stages
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cap_reg <= 3'h0;
      end else if (i_capture) begin
         cap_reg <= i_cap_data;
      end else if (i_shift) begin
         cap_reg <= {cap_reg[1:0], i_si};
      end
   end

   // ----------------------------------------------------------------
   // update stages
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn || !HAS_UPD) begin
         upd_reg <= 2'h0;
      end else if (i_update) begin
         upd_reg <= cap_reg[2:1];
      end
   end

   assign o_so  = cap_reg[2];
   assign o_upd = upd_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   AST_CELL_SHIFT: assert property (i_shift && !i_capture |=> cap_reg[0] == $past(i_si)
                                    && cap_reg[2:1] == $past(cap_reg[1:0]))
      else $error("scan cell did not shift");
   AST_CELL_UPDATE: assert property (HAS_UPD && i_update |=> o_upd == $past(cap_reg[2:1])
                                     ##1 (i_update || $stable(o_upd)))
      else $error("scan cell update stage wrong");

endmodule : bst_scan_cell

// ---- logic/bst_tap_port.sv ----
// Purpose: boundary-scan test access port with pin and macrocell scan chain
// Assumes: test clock, mode, data and pin levels are asynchronous to i_clk
// Notes:   i_clk must run well above four times the test clock rate
//
// Summary of operation
// - every dedicated input and bidirectional pin has its own scan cell.
// - no test-reset pin; controller enters reset state on power-up reset.
// - supports sample/preload, extest, bypass, idcode and highz instructions.
// - test port is optional; disabled, the four pins act as user I/O.
// - chain covers up to 32 bidirectional pins and four inputs.
// - each cell has three capture stages and up to two update stages.
// - two cell variants: one with update stages for bidirectional pins, one without for inputs and macrocells.
// - cells chained through capture stages from data in to data out.
// - capture stages sample pins, shift serially, and load update stages.
// - capture, shift and update strobes come from the controller only.
// - optional pull-ups on mode select and data input when configured.
`timescale 1ns/1ns
module bst_tap_port #(
   parameter int          N_IO    = bst_pkg::N_IO_DEF,
   parameter int          N_IN    = bst_pkg::N_IN_DEF,
   parameter int          N_MC    = bst_pkg::N_MC_DEF,
   parameter logic [31:0] ID_CODE = 32'h0A5C_3001     // arbitrary value
) (
   input  wire logic            i_clk,
   input  wire logic            i_rstn,
   input  wire logic            i_port_en,
   input  wire logic            i_pullup_en,
   input  wire logic            i_tck,
   input  wire logic            i_tms,
   input  wire logic            i_tdi,
   input  wire logic [N_IO+N_IN-1:0] i_pin_in,
   input  wire logic [N_IO-1:0] i_core_out,
   input  wire logic [N_IO-1:0] i_core_oe,
   input  wire logic [N_MC-1:0] i_mc_q,
   input  wire logic [N_MC-1:0] i_mc_fb,
   input  wire logic [N_MC-1:0] i_mc_oe,
   output logic                 o_tdo,
   output logic                 o_tdo_oe,
   output logic                 o_pullup_tms,
   output logic                 o_pullup_tdi,
   output logic [N_IO-1:0]      o_pin_out,
   output logic [N_IO-1:0]      o_pin_oe
);

   localparam int N_PIN  = N_IO + N_IN;
   localparam int N_CELL = N_PIN + N_MC;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (N_IO < 1 || N_IO > 32 || N_IN < 1 || N_IN > 4 || N_MC < 1 || ID_CODE[0] != 1'b1) begin
      $error("bst_tap_port: pin counts out of range or id code lsb not one");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0]       tck_reg;
   logic [1:0]       tms_reg;
   logic [1:0]       tdi_reg;
   logic [N_PIN-1:0] pin_s1_reg;
   logic [N_PIN-1:0] pin_s2_reg;
   logic             rise;
   logic             fall;

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         tck_reg    <= 3'h0;
         tms_reg    <= 2'h3;
         tdi_reg    <= 2'h3;
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end else begin
         tck_reg    <= {tck_reg[1:0], i_tck};
         tms_reg    <= {tms_reg[0], i_tms};
         tdi_reg    <= {tdi_reg[0], i_tdi};
         pin_s1_reg <= i_pin_in;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // edges come from stages two and three; stage one feeds stage two only
   assign rise = tck_reg[1] && !tck_reg[2];
   assign fall = !tck_reg[1] && tck_reg[2];

   // ----------------------------------------------------------------
   // controller
   // ----------------------------------------------------------------
   bst_pkg::bst_tap_state_t state_reg;
   bst_pkg::bst_tap_state_t state_next;
   logic                    tms;

   assign tms = tms_reg[1];

   always_comb begin
      unique case (state_reg)
         bst_pkg::ST_RESET:    state_next = tms ? bst_pkg::ST_RESET   : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE:     state_next = tms ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_DR:   state_next = tms ? bst_pkg::ST_SEL_IR  : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR:   state_next = tms ? bst_pkg::ST_EX1_DR  : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_SHIFT_DR: state_next = tms ? bst_pkg::ST_EX1_DR  : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_EX1_DR:   state_next = tms ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_PAUSE_DR;
         bst_pkg::ST_PAUSE_DR: state_next = tms ? bst_pkg::ST_EX2_DR  : bst_pkg::ST_PAUSE_DR;
         bst_pkg::ST_EX2_DR:   state_next = tms ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_UPD_DR:   state_next = tms ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_IR:   state_next = tms ? bst_pkg::ST_RESET   : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR:   state_next = tms ? bst_pkg::ST_EX1_IR  : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_SHIFT_IR: state_next = tms ? bst_pkg::ST_EX1_IR  : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_EX1_IR:   state_next = tms ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_PAUSE_IR;
         bst_pkg::ST_PAUSE_IR: state_next = tms ? bst_pkg::ST_EX2_IR  : bst_pkg::ST_PAUSE_IR;
         bst_pkg::ST_EX2_IR:   state_next = tms ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_UPD_IR:   state_next = tms ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
      endcase
   end

   // a disabled port is parked in reset so its pins are free for user I/O
   always_ff @(posedge i_clk) begin
      if (!i_rstn || !i_port_en) begin
         state_reg <= bst_pkg::ST_RESET;
      end else if (rise) begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // strobes and instruction register
   // ----------------------------------------------------------------
   logic [3:0] ir_sh_reg;
   logic [3:0] ir_reg;
   logic       cap_dr;
   logic       shift_dr;
   logic       upd_dr;
   logic       sel_bsr;
   logic       sel_id;

   assign cap_dr   = rise && state_reg == bst_pkg::ST_CAP_DR;
   assign shift_dr = rise && state_reg == bst_pkg::ST_SHIFT_DR;
   assign upd_dr   = fall && state_reg == bst_pkg::ST_UPD_DR;
   assign sel_bsr  = ir_reg == bst_pkg::IR_EXTEST || ir_reg == bst_pkg::IR_SAMPLE;
   assign sel_id   = ir_reg == bst_pkg::IR_IDCODE;

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ir_sh_reg <= bst_pkg::IR_CAPTURE;
         ir_reg    <= bst_pkg::IR_IDCODE;
      end else begin
         if (rise && state_reg == bst_pkg::ST_CAP_IR) begin
            ir_sh_reg <= bst_pkg::IR_CAPTURE;
         end else if (rise && state_reg == bst_pkg::ST_SHIFT_IR) begin
            ir_sh_reg <= {tdi_reg[1], ir_sh_reg[3:1]};
         end
         if (state_reg == bst_pkg::ST_RESET) begin
            ir_reg <= bst_pkg::IR_IDCODE;
         end else if (fall && state_reg == bst_pkg::ST_UPD_IR) begin
            ir_reg <= ir_sh_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // bypass and identification registers
   // ----------------------------------------------------------------
   logic        byp_reg;
   logic [31:0] id_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         byp_reg <= 1'b0;
         id_reg  <= '0;
      end else begin
         if (cap_dr) begin
            byp_reg <= 1'b0;
            id_reg  <= ID_CODE;
         end else if (shift_dr) begin
            byp_reg <= tdi_reg[1];
            id_reg  <= {tdi_reg[1], id_reg[31:1]};
         end
      end
   end

   // ----------------------------------------------------------------
   // scan chain
   // ----------------------------------------------------------------
   logic [N_CELL:0]       chain;
   logic [1:0]            upd [N_CELL];
   logic [2:0]            cap [N_CELL];

   assign chain[0] = tdi_reg[1];

   for (genvar k = 0; k < N_CELL; k++) begin : g_cell
      if (k < N_IO) begin : g_io
         assign cap[k] = {i_core_oe[k], i_core_out[k], pin_s2_reg[k]};
      end else if (k < N_PIN) begin : g_in
         assign cap[k] = {2'h0, pin_s2_reg[k]};
      end else begin : g_mc
         assign cap[k] = {i_mc_oe[k-N_PIN], i_mc_fb[k-N_PIN], i_mc_q[k-N_PIN]};
      end
      bst_scan_cell #(
         .HAS_UPD (k < N_IO)
      ) u_cell (
         .i_clk      (i_clk),
         .i_rstn     (i_rstn),
         .i_capture  (cap_dr && sel_bsr),
         .i_shift    (shift_dr && sel_bsr),
         .i_update   (upd_dr && sel_bsr),
         .i_si       (chain[k]),
         .i_cap_data (cap[k]),
         .o_so       (chain[k+1]),
         .o_upd      (upd[k])
      );
   end

   // ----------------------------------------------------------------
   // test data out, pull-ups and pin drivers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else if (fall) begin
         o_tdo_oe <= state_reg == bst_pkg::ST_SHIFT_DR
                     || state_reg == bst_pkg::ST_SHIFT_IR;
         if (state_reg == bst_pkg::ST_SHIFT_IR) begin
            o_tdo <= ir_sh_reg[0];
         end else if (sel_bsr) begin
            o_tdo <= chain[N_CELL];
         end else if (sel_id) begin
            o_tdo <= id_reg[0];
         end else begin
            o_tdo <= byp_reg;
         end
      end else if (!i_port_en) begin
         o_tdo_oe <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_pullup_tms <= 1'b0;
         o_pullup_tdi <= 1'b0;
      end else begin
         o_pullup_tms <= i_port_en && i_pullup_en;
         o_pullup_tdi <= i_port_en && i_pullup_en;
      end
   end

   for (genvar p = 0; p < N_IO; p++) begin : g_drv
      always_ff @(posedge i_clk) begin
         if (!i_rstn) begin
            o_pin_out[p] <= 1'b0;
            o_pin_oe[p]  <= 1'b0;
         end else if (ir_reg == bst_pkg::IR_EXTEST) begin
            o_pin_out[p] <= upd[p][bst_pkg::UPD_OUT];
            o_pin_oe[p]  <= upd[p][bst_pkg::UPD_OE];
         end else begin
            o_pin_out[p] <= i_core_out[p];
            o_pin_oe[p]  <= i_core_oe[p] && ir_reg != bst_pkg::IR_HIGHZ;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [2:0] tms_run_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rstn || !i_port_en) begin
         tms_run_reg <= 3'h0;
      end else if (rise) begin
         tms_run_reg <= !tms ? 3'h0 : (tms_run_reg == 3'h7 ? 3'h7 : tms_run_reg + 3'h1);
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_id_capture;
      cap_dr && sel_id;
   endsequence
   sequence s_id_loaded;
      id_reg == ID_CODE;
   endsequence

   AST_RESET_ENTRY: assert property (disable iff (1'b0) !i_rstn |=> state_reg == bst_pkg::ST_RESET
                                     && ir_reg == bst_pkg::IR_IDCODE)
      else $error("controller not in reset after power-up reset");
   AST_TMS_FIVE: assert property (tms_run_reg >= 3'(bst_pkg::TMS_RESET_EDGES)
                                  |-> state_reg == bst_pkg::ST_RESET)
      else $error("five high mode-select edges did not reach reset");
   AST_TDO_TRISTATE: assert property (fall && !(state_reg == bst_pkg::ST_SHIFT_DR
                                      || state_reg == bst_pkg::ST_SHIFT_IR) |=> !o_tdo_oe)
      else $error("data out driven outside shift");
   AST_TDO_SHIFT_OE: assert property (fall && state_reg == bst_pkg::ST_SHIFT_DR
                                      |=> o_tdo_oe)
      else $error("data out not driven in shift");
   AST_IDCODE_LOAD: assert property (s_id_capture |=> s_id_loaded)
      else $error("identification register not loaded at capture");
   AST_BYPASS_BIT: assert property (fall && state_reg == bst_pkg::ST_SHIFT_DR && !sel_bsr
                                    && !sel_id |=> o_tdo == $past(byp_reg))
      else $error("bypass bit not on data out");
   AST_HIGHZ_PINS: assert property (ir_reg == bst_pkg::IR_HIGHZ ##1 ir_reg == bst_pkg::IR_HIGHZ
                                    |-> o_pin_oe == '0)
      else $error("pins driven under highz");
   AST_EXTEST_PIN: assert property (ir_reg == bst_pkg::IR_EXTEST
                                    |=> o_pin_out[0] == $past(upd[0][bst_pkg::UPD_OUT]))
      else $error("extest pin not taken from update stage");
   AST_PORT_OFF: assert property (!i_port_en ##1 !i_port_en |=> state_reg == bst_pkg::ST_RESET
                                  && !o_tdo_oe && !o_pullup_tms)
      else $error("disabled port still active");
   AST_PULLUP: assert property (i_port_en && i_pullup_en |=> o_pullup_tdi && o_pullup_tms)
      else $error("pull-up request ignored");

endmodule : bst_tap_port

// ---- verification/bst_tester.sv ----
// Purpose: behavioural test-link controller that drives the scan port
// Assumes: test clock half period is 8 cycles of i_clk (64 ns period)
// Notes:   test clock stands low between operations; data out is taken at the rise
`timescale 1ns/1ns
module bst_tester (
   input  wire logic i_clk,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe,
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi
);
   logic oe_and;
   logic oe_or;

   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
      oe_and = 1'b1;
      oe_or = 1'b0;
   end

   // one test-clock period; callers start on a falling i_clk edge
   task automatic tick(input logic tms, input logic tdi, input logic samp, output logic tdo);
      o_tms = tms;
      o_tdi = tdi;
      repeat (8) @(negedge i_clk);
      // a released data-out line reads as the inverse, so a missing enable shows up
      tdo = i_tdo_oe ? i_tdo : ~i_tdo;
      if (samp) begin
         oe_and = oe_and & i_tdo_oe;
         oe_or = oe_or | i_tdo_oe;
      end
      o_tck = 1'b1;
      repeat (8) @(negedge i_clk);
      o_tck = 1'b0;
   endtask : tick

   // no reset pin, so five high mode-select rises force reset, then park in idle
   task automatic goto_idle();
      logic d;
      for (int i = 0; i < 5; i++) tick(1'b1, ~o_tdi, 1'b0, d);
      tick(1'b0, ~o_tdi, 1'b0, d);
   endtask : goto_idle

   // idle -> capture -> shift n bits lsb first -> update -> idle
   task automatic scan(input logic ir, input int n, input logic [255:0] din,
                       output logic [255:0] dout);
      logic d;
      dout = '0;
      tick(1'b1, ~o_tdi, 1'b0, d);
      if (ir) tick(1'b1, ~o_tdi, 1'b0, d);
      tick(1'b0, ~o_tdi, 1'b0, d);
      tick(1'b0, ~o_tdi, 1'b0, d);
      for (int i = 0; i < n; i++) tick(i == n - 1, din[i], 1'b1, dout[i]);
      tick(1'b1, ~o_tdi, 1'b0, d);
      tick(1'b0, ~o_tdi, 1'b0, d);
   endtask : scan
endmodule : bst_tester

// ---- verification/tb.sv ----
// Purpose: self-checking bench for the boundary-scan test port
// Assumes: bst_tester plays the external test controller
// Notes:   expectations come from the documented chain layout, not the design
`timescale 1ns/1ns
module tb;
   localparam logic [31:0] ID_VAL = 32'h1234_5671; // arbitrary value, bit 0 set
   logic clk = 1'b0;
   logic rstn, port_en, pullup_en, tck, tms, tdi, tdo, tdo_oe, pu_tms, pu_tdi;
   logic [35:0] pin_in;
   logic [31:0] core_out, core_oe, mc_q, mc_fb, mc_oe, pin_out, pin_oe;
   logic [255:0] din, dout;
   int          bad_count = 0;
   int          checks = 0;

   always #2 clk = ~clk;

   bst_tap_port #(.ID_CODE(ID_VAL)) i_dut (.i_clk(clk), .i_rstn(rstn), .i_port_en(port_en),
      .i_pullup_en(pullup_en), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_pin_in(pin_in),
      .i_core_out(core_out), .i_core_oe(core_oe), .i_mc_q(mc_q), .i_mc_fb(mc_fb),
      .i_mc_oe(mc_oe), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_pullup_tms(pu_tms),
      .o_pullup_tdi(pu_tdi), .o_pin_out(pin_out), .o_pin_oe(pin_oe));
   bst_tester i_tester (.i_clk(clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck),
      .o_tms(tms), .o_tdi(tdi));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // bit j of the shifted-out chain; cell 67 stage 2 leaves first
   function automatic logic [255:0] exp_chain();
      logic [255:0] e;
      logic [2:0]   v;
      int           c;
      e = '0;
      for (int p = 0; p < 204; p++) begin
         c = p / 3;
         if (c < 32) v = {core_oe[c], core_out[c], pin_in[c]};
         else if (c < 36) v = {2'b00, pin_in[c]};
         else v = {mc_oe[c-36], mc_fb[c-36], mc_q[c-36]};
         e[203-p] = v[p%3];
      end
      return e;
   endfunction : exp_chain

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      check("reset outputs", '0, 256'({tdo, tdo_oe, pu_tms, pu_tdi, pin_out, pin_oe}));
   endtask : t_reset

   task automatic t_idcode();
      i_tester.oe_and = 1'b1;
      i_tester.scan(1'b0, 32, '0, dout);
      check("idcode", 256'(ID_VAL), dout);
      check("tdo enable in shift", 256'(1'b1), 256'(i_tester.oe_and));
      check("tdo enable idle", '0, 256'(tdo_oe));
   endtask : t_idcode

   task automatic t_bypass();
      logic [3:0] codes [2];
      codes = '{bst_pkg::IR_BYPASS, 4'h5};
      foreach (codes[i]) begin
         i_tester.scan(1'b1, 4, 256'(codes[i]), dout);
         check("ir capture", 256'(bst_pkg::IR_CAPTURE), dout);
         i_tester.scan(1'b0, 3, 256'(3'b011), dout);
         check("bypass path", 256'(3'b110), dout);
      end
   endtask : t_bypass

   task automatic t_scan();
      pin_in = 36'h9_C3A5_1E77;
      core_out = 32'h3CA5_0F69;
      core_oe = 32'hF0F0_1234;
      mc_q = 32'h1357_9BDF;
      mc_fb = 32'h2468_ACE0;
      mc_oe = 32'hFEDC_BA98;
      din = {8{32'hC3A5_5A3C}};
      i_tester.scan(1'b1, 4, 256'(bst_pkg::IR_SAMPLE), dout);
      check("pins follow core", {core_oe, core_out}, 256'({pin_oe, pin_out}));
      i_tester.scan(1'b0, 204, din, dout);
      check("sampled chain", exp_chain(), dout);
      i_tester.scan(1'b1, 4, 256'(bst_pkg::IR_EXTEST), dout);
      for (int k = 0; k < 32; k++) begin
         check("extest out", 256'(din[202-3*k]), 256'(pin_out[k]));
         check("extest oe", 256'(din[201-3*k]), 256'(pin_oe[k]));
      end
      i_tester.scan(1'b1, 4, 256'(bst_pkg::IR_HIGHZ), dout);
      check("highz enables", '0, 256'(pin_oe));
      i_tester.scan(1'b1, 4, 256'(bst_pkg::IR_BYPASS), dout);
      check("core restored", {core_oe, core_out}, 256'({pin_oe, pin_out}));
   endtask : t_scan

   task automatic t_port_off();
      for (int i = 0; i < 4; i++) begin
         port_en = i[1];
         pullup_en = i[0];
         repeat (3) @(negedge clk);
         check("pull-ups", 256'({2{i == 3}}), 256'({pu_tms, pu_tdi}));
      end
      i_tester.oe_or = 1'b0;
      port_en = 1'b0;
      i_tester.scan(1'b0, 8, '1, dout);
      check("tdo enable when off", '0, 256'(i_tester.oe_or));
      port_en = 1'b1;
      i_tester.goto_idle();
      t_idcode();
   endtask : t_port_off

   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      conclude();
   end

   initial begin
      rstn = 1'b0;
      port_en = 1'b1;
      pullup_en = 1'b0;
      pin_in = '0;
      core_out = '0;
      core_oe = '0;
      mc_q = '0;
      mc_fb = '0;
      mc_oe = '0;
      repeat (5) @(negedge clk);
      t_reset();
      rstn = 1'b1;
      i_tester.goto_idle();
      t_idcode();
      t_bypass();
      t_scan();
      t_port_off();
      conclude();
   end
endmodule : tb
